// *** core/memory_area_base_registers.sv ***
// Memory area base register bank with display and capture update points
// Behaviour
// - Background X holds 10 bits 9..0, background Y 14 bits 13..0.
// - Video area bases carry address bits 22..10 only, lower bits zero.
// - Three video bases, high in bits 6..0, low in bits 15..10.
// - With auto-select set, display the area holding the latest capture.
// - Video base change: display at internal update, capture at frame sync rise.
// - Cursor base holds A15..A11 in bits 15..11, A22..A16 in bits 6..0.
// - Cursor base change takes effect only at the internal display update.
// - Render base, A22..A16 in bits 6..0, used only while select is 1.
// - Video, window, cursor and render registers keep contents through reset.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module memory_area_base_registers
    import mem_area_pkg::*;
(
    input wire logic core_clk, // 40 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [10:0] reg_addr, // Register byte offset
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [15:0] reg_rdata, // Read data, cycle after read strobe
    input wire logic display_update, // Internal display update pulse
    input wire logic capture_frame_sync_in, // Capture vertical sync level
    input wire logic capture_auto_select, // Auto-select latest capture area
    input wire logic [1:0] display_area_sel, // Area shown when auto-select is 0
    input wire logic [1:0] capture_area_idx, // Area being filled by capture
    input wire logic capture_done, // Pulse: capture area finished an image
    input wire logic render_base_select, // Render base select bit
    output logic [9:0] background_origin_x, // Background start X
    output logic [13:0] background_origin_y, // Background start Y
    output logic [22:0] display_video_base, // Display video base address
    output logic [22:0] capture_video_base, // Capture video base address
    output logic [1:0] display_video_idx, // Area now used for display
    output logic [9:0] video_window_width, // Window width, bit 0 zero
    output logic [15:0] video_window_height, // Window height register image
    output logic [22:0] cursor1_base, // Cursor 1 base in effect
    output logic [22:0] cursor2_base, // Cursor 2 base in effect
    output logic [22:0] render_base, // Render base address
    output logic render_base_valid, // Render base in use
    output logic updates_pending // A display video or cursor base waits for the display update
);
    // ======================================================================
    // State: programmed registers, capture bases, sync history, read path
    typedef struct packed {
        logic [15:0] bg_x;
        logic [15:0] bg_y;
        logic [15:0] va_hi0;
        logic [15:0] va_hi1;
        logic [15:0] va_hi2;
        logic [15:0] va_lo0;
        logic [15:0] va_lo1;
        logic [15:0] va_lo2;
        logic [15:0] vwin_w;
        logic [15:0] vwin_h;
        logic [15:0] cur1;
        logic [15:0] cur2;
        logic [15:0] rend;
        logic [12:0] cap0;
        logic [12:0] cap1;
        logic [12:0] cap2;
        logic sync_d;
        logic [1:0] latest;
        logic [15:0] rdata;
    } bank_type;
    bank_type s_r;
    bank_type s_nxt;

    // Address bits 22..10 from a video high/low pair; va_addr adds the zero low bits
    function automatic logic [12:0] va_join(input logic [15:0] hi, input logic [15:0] lo);
        va_join = {hi[6:0], lo[15:10]};
    endfunction : va_join

    function automatic logic [22:0] va_addr(input logic [12:0] a);
        va_addr = {a, 10'h000};
    endfunction : va_addr

    // Cursor register image to 23-bit address
    function automatic logic [22:0] cur_addr(input logic [15:0] r);
        cur_addr = {r[6:0], r[15:11], 11'h000};
    endfunction : cur_addr

    function automatic logic [12:0] pick3(input logic [1:0] i, input logic [12:0] a0,
                                          input logic [12:0] a1, input logic [12:0] a2);
        case (i)
            2'h0: pick3 = a0;
            2'h1: pick3 = a1;
            default: pick3 = a2;
        endcase
    endfunction : pick3

    logic sync_rise;
    logic [12:0] prog0;
    logic [12:0] prog1;
    logic [12:0] prog2;
    logic [38:0] disp_src;
    logic [38:0] disp_q;
    logic [15:0] c1_q;
    logic [15:0] c2_q;
    logic [2:0] pend;

    assign sync_rise = capture_frame_sync_in & ~s_r.sync_d;
    assign prog0 = va_join(s_r.va_hi0, s_r.va_lo0);
    assign prog1 = va_join(s_r.va_hi1, s_r.va_lo1);
    assign prog2 = va_join(s_r.va_hi2, s_r.va_lo2);
    assign disp_src = {prog2, prog1, prog0};

    // ======================================================================
    // Register writes, capture-side copies and read path
    // Reset touches only the sync history, latest index and read data; all
    // programmed fields deliberately have no reset so software setup survives.
    always_comb begin
        s_nxt = s_r;
        s_nxt.sync_d = capture_frame_sync_in;
        s_nxt.rdata = 16'h0000;
        if (reg_wr) begin
            case (reg_addr)
                OFS_BG_X: s_nxt.bg_x = reg_wdata & MSK_BG_X;
                OFS_BG_Y: s_nxt.bg_y = reg_wdata & MSK_BG_Y;
                OFS_VA0_HI: s_nxt.va_hi0 = reg_wdata & MSK_HI7;
                OFS_VA0_LO: s_nxt.va_lo0 = reg_wdata & MSK_VA_LO;
                OFS_VA1_HI: s_nxt.va_hi1 = reg_wdata & MSK_HI7;
                OFS_VA1_LO: s_nxt.va_lo1 = reg_wdata & MSK_VA_LO;
                OFS_VA2_HI: s_nxt.va_hi2 = reg_wdata & MSK_HI7;
                OFS_VA2_LO: s_nxt.va_lo2 = reg_wdata & MSK_VA_LO;
                OFS_VWIN_W: s_nxt.vwin_w = reg_wdata & MSK_VWIN_W;
                OFS_VWIN_H: s_nxt.vwin_h = reg_wdata & MSK_VWIN_H;
                OFS_CUR1: s_nxt.cur1 = reg_wdata & MSK_CUR;
                OFS_CUR2: s_nxt.cur2 = reg_wdata & MSK_CUR;
                OFS_RENDER: s_nxt.rend = reg_wdata & MSK_HI7;
                default: s_nxt.bg_x = s_r.bg_x;
            endcase
        end
        // Capture sees new bases only at the frame sync rising edge
        if (sync_rise) begin
            s_nxt.cap0 = prog0;
            s_nxt.cap1 = prog1;
            s_nxt.cap2 = prog2;
        end
        // Latest finished capture area, for auto-select display
        if (capture_done) begin
            s_nxt.latest = capture_area_idx;
        end
        if (reg_rd) begin
            case (reg_addr)
                OFS_BG_X: s_nxt.rdata = s_r.bg_x;
                OFS_BG_Y: s_nxt.rdata = s_r.bg_y;
                OFS_VA0_HI: s_nxt.rdata = s_r.va_hi0;
                OFS_VA0_LO: s_nxt.rdata = s_r.va_lo0;
                OFS_VA1_HI: s_nxt.rdata = s_r.va_hi1;
                OFS_VA1_LO: s_nxt.rdata = s_r.va_lo1;
                OFS_VA2_HI: s_nxt.rdata = s_r.va_hi2;
                OFS_VA2_LO: s_nxt.rdata = s_r.va_lo2;
                OFS_VWIN_W: s_nxt.rdata = s_r.vwin_w;
                OFS_VWIN_H: s_nxt.rdata = s_r.vwin_h;
                OFS_CUR1: s_nxt.rdata = s_r.cur1;
                OFS_CUR2: s_nxt.rdata = s_r.cur2;
                OFS_RENDER: s_nxt.rdata = s_r.rend;
                default: s_nxt.rdata = 16'h0000;
            endcase
        end
        if (rst) begin
            s_nxt.sync_d = 1'b1; // A sync already high is not a rise
            s_nxt.latest = 2'h0;
            s_nxt.rdata = 16'h0000;
        end
    end

    // Register stage; programmed fields keep their value through reset
    always_ff @(posedge core_clk) begin
        s_r <= s_nxt;
    end

    // ======================================================================
    // Display-side working copies that move only on the internal update
    shadow_reg #(.W(39)) u_disp_va (
        .core_clk(core_clk),
        .rst(rst),
        .src(disp_src),
        .load(display_update),
        .q(disp_q),
        .pending(pend[0])
    );

    shadow_reg #(.W(16)) u_cur1 (
        .core_clk(core_clk),
        .rst(rst),
        .src(s_r.cur1),
        .load(display_update),
        .q(c1_q),
        .pending(pend[1])
    );

    shadow_reg #(.W(16)) u_cur2 (
        .core_clk(core_clk),
        .rst(rst),
        .src(s_r.cur2),
        .load(display_update),
        .q(c2_q),
        .pending(pend[2])
    );

    // ======================================================================
    // Outputs
    assign display_video_idx = capture_auto_select ? s_r.latest : display_area_sel;
    assign display_video_base = va_addr(pick3(display_video_idx, disp_q[12:0],
                                              disp_q[25:13], disp_q[38:26]));
    assign capture_video_base = va_addr(pick3(capture_area_idx, s_r.cap0, s_r.cap1,
                                              s_r.cap2));
    assign background_origin_x = s_r.bg_x[9:0];
    assign background_origin_y = s_r.bg_y[13:0];
    assign video_window_width = s_r.vwin_w[9:0];
    assign video_window_height = s_r.vwin_h;
    assign cursor1_base = cur_addr(c1_q);
    assign cursor2_base = cur_addr(c2_q);
    // Render base is zero unless selected, so a consumer cannot misuse it
    assign render_base = render_base_select ? {s_r.rend[6:0], 16'h0000} : 23'h000000;
    assign render_base_valid = render_base_select;
    assign updates_pending = |pend;
    assign reg_rdata = s_r.rdata;

    // ======================================================================
    // Checks
    // Hold checks use $stable so never-written fields, unknown until set up, pass
    AST_BG_X_WIDTH: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == OFS_BG_X |=> background_origin_x == $past(reg_wdata[9:0]))
        else $error("background x not stored");
    AST_BG_KEEP_RESET: assert property (@(posedge core_clk)
        rst && !reg_wr |=> $stable(background_origin_y))
        else $error("background y changed by reset");
    AST_VA_LOW_ZERO: assert property (@(posedge core_clk) disable iff (rst)
        sync_rise && capture_area_idx == 2'h0 ##1 capture_area_idx == 2'h0
        |-> capture_video_base == {$past(s_r.va_hi0[6:0]), $past(s_r.va_lo0[15:10]), 10'h000})
        else $error("video base not built from address bits 22..10");
    AST_VA_SPLIT: assert property (@(posedge core_clk) disable iff (rst)
        reg_wr && reg_addr == OFS_VA0_LO |=> s_r.va_lo0[9:0] == 10'h000)
        else $error("video low field holds unused bits");
    AST_AUTO_SEL: assert property (@(posedge core_clk) disable iff (rst)
        capture_done && capture_auto_select ##1 capture_auto_select && !capture_done
        |-> display_video_idx == $past(capture_area_idx))
        else $error("auto-select not following latest capture");
    AST_CAP_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !sync_rise |=> $stable(s_r.cap0))
        else $error("capture base changed without sync rise");
    AST_DISP_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !display_update |=> $stable(disp_q))
        else $error("display base changed without update");
    AST_CUR_LOAD: assert property (@(posedge core_clk) disable iff (rst)
        display_update |=> cursor1_base == cur_addr($past(s_r.cur1)))
        else $error("cursor base not taken at update");
    AST_CUR_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        !display_update |=> $stable(cursor2_base))
        else $error("cursor base changed without update");
    AST_RENDER_GATE: assert property (@(posedge core_clk) disable iff (rst)
        !render_base_select |-> render_base == 23'h000000)
        else $error("render base used while not selected");
    AST_KEEP_RESET: assert property (@(posedge core_clk)
        rst && !reg_wr |=> $stable(s_r.rend) && $stable(s_r.vwin_w))
        else $error("programmed register changed by reset");
    COV_SYNC: cover property (@(posedge core_clk) disable iff (rst) sync_rise);
    COV_UPDATE: cover property (@(posedge core_clk) disable iff (rst)
        updates_pending ##1 display_update);
    COV_AUTO: cover property (@(posedge core_clk) disable iff (rst)
        capture_auto_select && capture_done);
    COV_READ: cover property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == OFS_CUR1);
endmodule : memory_area_base_registers

// *** core/mem_area_pkg.sv ***
// Package: offsets, field layouts and widths of the memory area base register bank
package mem_area_pkg;
    // =====================================================================
    // Register offsets (byte offsets on the 16-bit register port)
    localparam logic [10:0] OFS_BG_X = 11'h04C;
    localparam logic [10:0] OFS_BG_Y = 11'h04E;
    localparam logic [10:0] OFS_VA0_HI = 11'h062;
    localparam logic [10:0] OFS_VA0_LO = 11'h064;
    localparam logic [10:0] OFS_VA1_HI = 11'h066;
    localparam logic [10:0] OFS_VA1_LO = 11'h068;
    localparam logic [10:0] OFS_VA2_HI = 11'h06A;
    localparam logic [10:0] OFS_VA2_LO = 11'h06C;
    localparam logic [10:0] OFS_VWIN_W = 11'h06E;
    localparam logic [10:0] OFS_VWIN_H = 11'h070;
    localparam logic [10:0] OFS_CUR1 = 11'h07C;
    localparam logic [10:0] OFS_CUR2 = 11'h07E;
    localparam logic [10:0] OFS_RENDER = 11'h098;
    // =====================================================================
    // Field masks of the writable bits
    localparam logic [15:0] MSK_BG_X = 16'h03FF;
    localparam logic [15:0] MSK_BG_Y = 16'h3FFF;
    localparam logic [15:0] MSK_HI7 = 16'h007F;
    localparam logic [15:0] MSK_VA_LO = 16'hFC00;
    localparam logic [15:0] MSK_VWIN_W = 16'h03FE;
    localparam logic [15:0] MSK_VWIN_H = 16'hFE00;
    localparam logic [15:0] MSK_CUR = 16'hF87F;
    // Number of video areas
    localparam int NUM_VA = 3;
    // Shadow-copy states of one update channel
    typedef enum logic [0:0] {SH_IDLE, SH_PENDING} shadow_state_type;
endpackage : mem_area_pkg

// *** core/shadow_reg.sv ***
// Shadow register: holds a working copy that follows its source on an update strobe
`timescale 1ns/1ps
module shadow_reg
    import mem_area_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic core_clk, // Clock
    input wire logic rst, // Synchronous reset, working copy kept
    input wire logic [W-1:0] src, // Programmed value
    input wire logic load, // One-cycle update strobe
    output logic [W-1:0] q, // Working copy
    output logic pending // Programmed value has differed from copy since the last load
);
    typedef struct packed {
        logic [W-1:0] copy;
        shadow_state_type st;
    } sh_state_type;
    sh_state_type s_r;
    sh_state_type s_nxt;

    // ==========================================================
    // Copy follows source only on the strobe; reset keeps the copy
    always_comb begin
        s_nxt = s_r;
        if (load) begin
            s_nxt.copy = src;
            s_nxt.st = SH_IDLE;
        end else if (src != s_r.copy) begin
            s_nxt.st = SH_PENDING;
        end
        if (rst) begin
            s_nxt.st = SH_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        s_r <= s_nxt;
    end

    assign q = s_r.copy;
    assign pending = (s_r.st == SH_PENDING);
endmodule : shadow_reg

// *** tb/tb_memory_area_base_registers.sv ***
// Testbench for the memory area base register bank
`timescale 1ns/1ps
module tb_memory_area_base_registers;
    import mem_area_pkg::*;
    // =====================================================================
    // Stimulus and observed signals
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [10:0] reg_addr = 11'h000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic display_update = 1'b0;
    logic capture_frame_sync_in = 1'b0;
    logic capture_auto_select = 1'b0;
    logic [1:0] display_area_sel = 2'h0;
    logic [1:0] capture_area_idx = 2'h0;
    logic capture_done = 1'b0;
    logic render_base_select = 1'b0;
    logic [15:0] reg_rdata;
    logic [9:0] background_origin_x;
    logic [13:0] background_origin_y;
    logic [22:0] display_video_base;
    logic [22:0] capture_video_base;
    logic [1:0] display_video_idx;
    logic [9:0] video_window_width;
    logic [15:0] video_window_height;
    logic [22:0] cursor1_base;
    logic [22:0] cursor2_base;
    logic [22:0] render_base;
    logic render_base_valid;
    logic updates_pending;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [10:0] ofs_tab [13] = '{OFS_BG_X, OFS_BG_Y, OFS_VA0_HI, OFS_VA0_LO, OFS_VA1_HI,
        OFS_VA1_LO, OFS_VA2_HI, OFS_VA2_LO, OFS_VWIN_W, OFS_VWIN_H, OFS_CUR1, OFS_CUR2, OFS_RENDER};
    logic [15:0] msk_tab [13] = '{MSK_BG_X, MSK_BG_Y, MSK_HI7, MSK_VA_LO, MSK_HI7, MSK_VA_LO,
        MSK_HI7, MSK_VA_LO, MSK_VWIN_W, MSK_VWIN_H, MSK_CUR, MSK_CUR, MSK_HI7};
    logic [1:0] sel_exp [4] = '{2'h0, 2'h1, 2'h2, 2'h3};

    memory_area_base_registers dut (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .display_update(display_update), .capture_frame_sync_in(capture_frame_sync_in),
        .capture_auto_select(capture_auto_select), .display_area_sel(display_area_sel),
        .capture_area_idx(capture_area_idx), .capture_done(capture_done),
        .render_base_select(render_base_select),
        .background_origin_x(background_origin_x), .background_origin_y(background_origin_y),
        .display_video_base(display_video_base), .capture_video_base(capture_video_base),
        .display_video_idx(display_video_idx), .video_window_width(video_window_width),
        .video_window_height(video_window_height), .cursor1_base(cursor1_base),
        .cursor2_base(cursor2_base), .render_base(render_base),
        .render_base_valid(render_base_valid), .updates_pending(updates_pending)
    );

    // =====================================================================
    // Clock, 25 ns period
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // =====================================================================
    // Expected addresses, built from the field layouts
    function automatic logic [22:0] cexp(input logic [15:0] r);
        return {r[6:0], r[15:11], 11'h000};
    endfunction : cexp
    function automatic logic [22:0] vexp(input logic [15:0] hi, input logic [15:0] lo);
        return {hi[6:0], lo[15:10], 10'h000};
    endfunction : vexp

    task automatic chk(input logic [22:0] seen, input logic [22:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // The write strobe is left high so a following access can go back to back
    task automatic wr(input logic [10:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
    endtask : wr
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge core_clk);
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
        end
    endtask : idle
    // Read data stands one cycle only, then falls back to zero
    task automatic rd_chk(input logic [10:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        idle(1);
        #1 chk(23'(reg_rdata), 23'(exp));
        idle(1);
        #1 chk(23'(reg_rdata), 23'h000000);
    endtask : rd_chk
    task automatic upd();
        idle(1);
        display_update <= 1'b1;
        idle(1);
        display_update <= 1'b0;
        #1;
    endtask : upd
    // A sync rise, held long enough for the capture copy to be taken
    task automatic vsync();
        @(posedge core_clk);
        capture_frame_sync_in <= 1'b1;
        repeat (3) @(posedge core_clk);
        capture_frame_sync_in <= 1'b0;
        #1;
    endtask : vsync

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    // =====================================================================
    // Watchdog: a hung run is counted as a mismatch
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        $display("wrong value at %0t: run did not finish", $time);
        stop_test();
    end

    // =====================================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        foreach (ofs_tab[i]) begin
            wr(ofs_tab[i], 16'hFFFF);
            rd_chk(ofs_tab[i], msk_tab[i]);
            wr(ofs_tab[i], 16'h5A5A);
            rd_chk(ofs_tab[i], 16'h5A5A & msk_tab[i]);
        end
        wr(11'h050, 16'hFFFF);
        rd_chk(11'h050, 16'h0000);
        rd_chk(OFS_BG_X, 16'h025A);
        chk(23'(background_origin_x), 23'h00025A);
        chk(23'(background_origin_y), 23'h001A5A);
        chk(23'(video_window_width), 23'h00025A);
        chk(23'(video_window_height), 23'h005A00);
        $display("test register map done");
        // Cursor bases move only at the display update
        upd();
        chk(cursor1_base, cexp(16'h585A));
        chk(23'(updates_pending), 23'h000000);
        wr(OFS_CUR1, 16'hA7A5);
        wr(OFS_CUR2, 16'h07FF);
        idle(2);
        #1 chk(cursor1_base, cexp(16'h585A));
        chk(23'(updates_pending), 23'h000001);
        upd();
        chk(cursor1_base, cexp(16'hA025));
        chk(cursor2_base, cexp(16'h007F));
        $display("test cursor update done");
        // Video base: display at update, capture at sync rise
        chk(display_video_base, vexp(16'h005A, 16'h5800));
        vsync();
        chk(capture_video_base, vexp(16'h005A, 16'h5800));
        wr(OFS_VA0_HI, 16'h0033);
        wr(OFS_VA0_LO, 16'hFC00);
        wr(OFS_VA1_HI, 16'h0011);
        wr(OFS_VA1_LO, 16'h0400);
        wr(OFS_VA2_HI, 16'h0022);
        wr(OFS_VA2_LO, 16'h0800);
        idle(2);
        #1 chk(display_video_base, vexp(16'h005A, 16'h5800));
        upd();
        chk(display_video_base, vexp(16'h0033, 16'hFC00));
        chk(capture_video_base, vexp(16'h005A, 16'h5800));
        vsync();
        chk(capture_video_base, vexp(16'h0033, 16'hFC00));
        for (int s = 0; s < 4; s++) begin
            @(posedge core_clk);
            display_area_sel <= 2'(s);
            #1 chk(23'(display_video_idx), 23'(sel_exp[s]));
        end
        chk(display_video_base, vexp(16'h0022, 16'h0800));
        // Auto-select follows the last finished capture
        @(posedge core_clk);
        display_area_sel <= 2'h0;
        capture_auto_select <= 1'b1;
        capture_area_idx <= 2'h1;
        capture_done <= 1'b1;
        @(posedge core_clk);
        capture_done <= 1'b0;
        #1 chk(23'(display_video_idx), 23'h000001);
        chk(display_video_base, vexp(16'h0011, 16'h0400));
        $display("test video areas done");
        // Render base is only in use while selected
        @(posedge core_clk);
        render_base_select <= 1'b1;
        #1 chk(render_base, 23'h5A0000);
        chk(23'(render_base_valid), 23'h000001);
        @(posedge core_clk);
        render_base_select <= 1'b0;
        #1 chk(23'(render_base_valid), 23'h000000);
        chk(render_base, 23'h000000);
        $display("test render base done");
        // Mid-run reset keeps every programmed value
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        rd_chk(OFS_BG_Y, 16'h1A5A);
        rd_chk(OFS_CUR1, 16'hA025);
        rd_chk(OFS_VA0_LO, 16'hFC00);
        rd_chk(OFS_RENDER, 16'h005A);
        chk(23'(background_origin_x), 23'h00025A);
        chk(cursor1_base, cexp(16'hA025));
        chk(23'(video_window_width), 23'h00025A);
        $display("test reset retention done");
        stop_test();
    end
endmodule : tb_memory_area_base_registers
